// ==== design/gated_counter_map.svh ====
/*
  Register map, field positions, reset values and timing counts of the gated
  sixteen-bit event counter. Assumes a 32-bit classic Wishbone slave decoding
  an 8-bit byte address; each register sits in the low bits of one word.
*/
// Function
// - No-sync external clock counts unsynchronised edges
// - Asynchronous mode counts on through Sleep, wakes
// - Mode switches may drop or add one count
// - Byte reads while running return valid value
// - Gate source is pin or comparator output
// - Gate enable ignored when off, else gates
// - Gate invert picks high or low counting
// - Count wraps FFFF to 0000, sets flag
// - Interrupt needs overflow, peripheral, global enables
// - Wake needs on, overflow and peripheral enables
// - Compare trigger clears count, no flag
// - Count write beats coincident compare trigger
// - Counter clock can resynchronise comparator output
// - First rising edge needs prior falling edge
// - Prescale codes divide by 1, 2, 4, 8
// - Low-power oscillator only with internal oscillator
// - Internal clock ignores the no-sync bit
// - Source select: pin edges or clock/4
// - Timer on bit; control resets zero
// - Count byte writes load the counter
// - Prescaler hidden, cleared on count write
`ifndef GATED_COUNTER_MAP_SVH
`define GATED_COUNTER_MAP_SVH

`define TC_OFF_CONTROL    8'h00
`define TC_OFF_COUNT_LO   8'h04
`define TC_OFF_COUNT_HI   8'h08
`define TC_OFF_FLAG       8'h0C
`define TC_OFF_ENABLE     8'h10
`define TC_OFF_IRQ_CTRL   8'h14
`define TC_OFF_CMP_CTRL   8'h18
`define TC_OFF_STATUS     8'h1C

`define TC_BIT_ON         0
`define TC_BIT_CS         1
`define TC_BIT_NOSYNC     2
`define TC_BIT_LPOSC      3
`define TC_BIT_PS_LO      4
`define TC_BIT_PS_HI      5
`define TC_BIT_GE         6
`define TC_BIT_GINV       7

`define TC_BIT_OVF_FLAG   0
`define TC_BIT_OVF_IE     0
`define TC_BIT_PERIPHERAL_IRQ_ENABLE       6
`define TC_BIT_GIE        7
`define TC_BIT_CMP_SYNC   0
`define TC_BIT_GSS        1

`define TC_RST_CONTROL    8'h00
`define TC_RST_CMP_CTRL   2'h2
`define TC_RST_COUNT      16'h0000
`define TC_COUNT_MAX      16'hFFFF

`define TC_PHASE_LAST     2'h3

`endif

// ==== design/gated_counter_pkg.sv ====
/*
  Types of the gated sixteen-bit event counter: clock source selection and
  the single packed state record. Assumes gated_counter_map.svh for values.
*/
`default_nettype none
package gated_counter_pkg;

  typedef enum logic [1:0] {
    SRC_INTERNAL,
    SRC_EXT_SYNC,
    SRC_EXT_ASYNC
  } src_e;

  typedef struct packed {
    logic [7:0]  control;
    logic [1:0]  cmp_ctrl;
    logic [15:0] count;
    logic [2:0]  presc;
    logic        ovf_flag;
    logic        ovf_ie;
    logic        peripheral_irq_enable;
    logic        global_irq_enable;
    logic [1:0]  phase;
    logic        pin_fast;
    logic        pin_phase;
    logic        seen_fall;
    logic        comp_sync;
    logic        lp_osc;
    logic        irq;
    logic        wake;
    logic        ack;
    logic [31:0] rdata;
  } state_s;

endpackage : gated_counter_pkg
`default_nettype wire

// ==== design/gated_counter.sv ====
/*
  Gated sixteen-bit event counter with control, flag and enable registers on
  a classic Wishbone slave. Assumes CLK is the oscillator; the instruction
  clock is CLK/4. All inputs are synchronous to CLK.
*/
`include "gated_counter_map.svh"
`default_nettype none
module gated_counter (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        EXT_CLK_PIN,
  input  wire logic        GATE_PIN,
  input  wire logic        COMP_OUT,
  input  wire logic        SPECIAL_TRIGGER,
  input  wire logic        SLEEP,
  input  wire logic        INTERNAL_OSC_NO_CLOCK_OUTPUT_PIN,
  output logic             IRQ_REQ,
  output logic             WAKE_REQ,
  output logic             LP_OSC_EN,
  output logic             COMP_SYNC_OUT
);

  gated_counter_pkg::state_s st;
  gated_counter_pkg::state_s next_st;

  function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] off);
    addr_hit = (adr[7:2] == off[7:2]);
  endfunction : addr_hit

  function automatic logic presc_last(input logic [2:0] cnt, input logic [1:0] code);
    case (code)
      2'h0:    presc_last = 1'b1;
      2'h1:    presc_last = (cnt == 3'h1);
      2'h2:    presc_last = (cnt == 3'h3);
      default: presc_last = (cnt == 3'h7);
    endcase
  endfunction : presc_last

  gated_counter_pkg::src_e src;
  logic req;
  logic wr;
  logic rd;
  logic instr_tick;
  logic q_tick;
  logic rise_sync;
  logic fall_sync;
  logic rise_async;
  logic fall_async;
  logic src_tick;
  logic ext_fall;
  logic gate_raw;
  logic gate_active;
  logic run;
  logic do_inc;
  logic wr_lo;
  logic wr_hi;
  logic overflow;

  always_comb begin
    next_st = st;
    src = gated_counter_pkg::SRC_INTERNAL;
    src_tick = 1'b0;
    ext_fall = 1'b0;
    do_inc = 1'b0;
    overflow = 1'b0;

    req = WB_CYC_I & WB_STB_I & ~st.ack;
    wr = req & WB_WE_I & WB_SEL_I[0];
    rd = req & ~WB_WE_I;
    next_st.ack = req;
    wr_lo = wr & addr_hit(WB_ADR_I, `TC_OFF_COUNT_LO);
    wr_hi = wr & addr_hit(WB_ADR_I, `TC_OFF_COUNT_HI);

    // Phase clocks freeze in Sleep, so only the no-sync path keeps counting
    if (!SLEEP) begin
      next_st.phase = st.phase + 2'h1;
    end
    instr_tick = ~SLEEP & (st.phase == `TC_PHASE_LAST);
    q_tick = ~SLEEP & st.phase[0];

    // Synchronous path samples the pin only on phase ticks
    if (q_tick) begin
      next_st.pin_phase = EXT_CLK_PIN;
    end
    rise_sync = q_tick & EXT_CLK_PIN & ~st.pin_phase;
    fall_sync = q_tick & ~EXT_CLK_PIN & st.pin_phase;
    // Unsynchronised path sees every sample, Sleep or not
    next_st.pin_fast = EXT_CLK_PIN;
    rise_async = EXT_CLK_PIN & ~st.pin_fast;
    fall_async = ~EXT_CLK_PIN & st.pin_fast;

    if (!st.control[`TC_BIT_CS]) begin
      src = gated_counter_pkg::SRC_INTERNAL;
    end else if (st.control[`TC_BIT_NOSYNC]) begin
      src = gated_counter_pkg::SRC_EXT_ASYNC;
    end else begin
      src = gated_counter_pkg::SRC_EXT_SYNC;
    end

    // Each edge path keeps its own pin history; a mode switch may skip or add one
    case (src)
      gated_counter_pkg::SRC_INTERNAL: begin
        src_tick = instr_tick;
      end
      gated_counter_pkg::SRC_EXT_SYNC: begin
        src_tick = rise_sync & st.seen_fall;
        ext_fall = fall_sync;
      end
      gated_counter_pkg::SRC_EXT_ASYNC: begin
        src_tick = rise_async & st.seen_fall;
        ext_fall = fall_async;
      end
      default: begin
        src_tick = 1'b0;
      end
    endcase

    if (!st.control[`TC_BIT_ON] || !st.control[`TC_BIT_CS]) begin
      next_st.seen_fall = 1'b0;
    end else if (ext_fall) begin
      next_st.seen_fall = 1'b1;
    end

    // Comparator output retimed on the counting clock
    if (src_tick) begin
      next_st.comp_sync = COMP_OUT;
    end

    if (st.cmp_ctrl[`TC_BIT_GSS]) begin
      gate_raw = st.cmp_ctrl[`TC_BIT_CMP_SYNC] ? st.comp_sync : COMP_OUT;
    end else begin
      gate_raw = GATE_PIN;
    end
    gate_active = st.control[`TC_BIT_GINV] ? gate_raw : ~gate_raw;
    run = st.control[`TC_BIT_ON] & (~st.control[`TC_BIT_GE] | gate_active);

    // Stopped or gated off: prescaler and count both hold
    if (run && src_tick) begin
      if (presc_last(st.presc, st.control[`TC_BIT_PS_HI:`TC_BIT_PS_LO])) begin
        next_st.presc = 3'h0;
        do_inc = 1'b1;
      end else begin
        next_st.presc = st.presc + 3'h1;
      end
    end

    // Write beats trigger beats increment
    if (wr_lo || wr_hi) begin
      next_st.presc = 3'h0;
      if (wr_lo) begin
        next_st.count[7:0] = WB_DAT_I[7:0];
      end
      if (wr_hi) begin
        next_st.count[15:8] = WB_DAT_I[7:0];
      end
    end else if (SPECIAL_TRIGGER) begin
      next_st.count = `TC_RST_COUNT;
    end else if (do_inc) begin
      next_st.count = st.count + 16'h0001;
      overflow = (st.count == `TC_COUNT_MAX);
    end

    if (wr && addr_hit(WB_ADR_I, `TC_OFF_CONTROL)) begin
      next_st.control = WB_DAT_I[7:0];
    end
    if (wr && addr_hit(WB_ADR_I, `TC_OFF_CMP_CTRL)) begin
      next_st.cmp_ctrl = WB_DAT_I[1:0];
    end
    if (wr && addr_hit(WB_ADR_I, `TC_OFF_ENABLE)) begin
      next_st.ovf_ie = WB_DAT_I[`TC_BIT_OVF_IE];
    end
    if (wr && addr_hit(WB_ADR_I, `TC_OFF_IRQ_CTRL)) begin
      next_st.peripheral_irq_enable = WB_DAT_I[`TC_BIT_PERIPHERAL_IRQ_ENABLE];
      next_st.global_irq_enable = WB_DAT_I[`TC_BIT_GIE];
    end
    // Only software clears the flag; a same-cycle overflow wins
    if (wr && addr_hit(WB_ADR_I, `TC_OFF_FLAG)) begin
      next_st.ovf_flag = WB_DAT_I[`TC_BIT_OVF_FLAG];
    end
    if (overflow) begin
      next_st.ovf_flag = 1'b1;
    end

    next_st.irq = next_st.ovf_flag & next_st.ovf_ie & next_st.peripheral_irq_enable & next_st.global_irq_enable;
    next_st.wake = next_st.ovf_flag & next_st.ovf_ie & next_st.peripheral_irq_enable
                   & next_st.control[`TC_BIT_ON];
    // Oscillator stays off outside internal-oscillator-without-clock-out mode
    next_st.lp_osc = next_st.control[`TC_BIT_LPOSC] & INTERNAL_OSC_NO_CLOCK_OUTPUT_PIN;

    // Reads come from the live count in one clock, so each byte is whole
    if (rd) begin
      next_st.rdata = 32'h0000_0000;
      if (addr_hit(WB_ADR_I, `TC_OFF_CONTROL)) begin
        next_st.rdata[7:0] = st.control;
      end else if (addr_hit(WB_ADR_I, `TC_OFF_COUNT_LO)) begin
        next_st.rdata[7:0] = st.count[7:0];
      end else if (addr_hit(WB_ADR_I, `TC_OFF_COUNT_HI)) begin
        next_st.rdata[7:0] = st.count[15:8];
      end else if (addr_hit(WB_ADR_I, `TC_OFF_FLAG)) begin
        next_st.rdata[`TC_BIT_OVF_FLAG] = st.ovf_flag;
      end else if (addr_hit(WB_ADR_I, `TC_OFF_ENABLE)) begin
        next_st.rdata[`TC_BIT_OVF_IE] = st.ovf_ie;
      end else if (addr_hit(WB_ADR_I, `TC_OFF_IRQ_CTRL)) begin
        next_st.rdata[`TC_BIT_PERIPHERAL_IRQ_ENABLE] = st.peripheral_irq_enable;
        next_st.rdata[`TC_BIT_GIE] = st.global_irq_enable;
      end else if (addr_hit(WB_ADR_I, `TC_OFF_CMP_CTRL)) begin
        next_st.rdata[1:0] = st.cmp_ctrl;
      end else if (addr_hit(WB_ADR_I, `TC_OFF_STATUS)) begin
        next_st.rdata[2:0] = {st.seen_fall, st.wake, st.lp_osc};
      end
    end else if (!req) begin
      next_st.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= '0;
      st.control <= `TC_RST_CONTROL;
      st.cmp_ctrl <= `TC_RST_CMP_CTRL;
      st.count <= `TC_RST_COUNT;
    end else begin
      st <= next_st;
    end
  end

  assign WB_DAT_O = st.rdata;
  assign WB_ACK_O = st.ack;
  assign IRQ_REQ = st.irq;
  assign WAKE_REQ = st.wake;
  assign LP_OSC_EN = st.lp_osc;
  assign COMP_SYNC_OUT = st.comp_sync;

endmodule : gated_counter
`default_nettype wire

// ==== testbench/gated_counter_monitor.sv ====
/*
  Checker for the counter's bus answers and request outputs.
  Assumes it is bound to every gated_counter instance.
*/
`default_nettype none
module gated_counter_monitor (
  input wire logic        CLK,
  input wire logic        RESETN,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        COMP_OUT,
  input wire logic        INTERNAL_OSC_NO_CLOCK_OUTPUT_PIN,
  input wire logic        IRQ_REQ,
  input wire logic        WAKE_REQ,
  input wire logic        LP_OSC_EN,
  input wire logic        COMP_SYNC_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire logic req;
  assign req = WB_CYC_I && WB_STB_I;

  ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held too long");
  ack_answer_a: assert property (req && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing");
  data_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside answer");
  byte_wide_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (req && !WB_WE_I && !WB_ACK_O && WB_ADR_I == 8'h40
    |=> WB_DAT_O == 32'h0) else $error("unmapped read not zero");
  lp_osc_gate_a: assert property (LP_OSC_EN |-> $past(INTERNAL_OSC_NO_CLOCK_OUTPUT_PIN))
    else $error("lp oscillator without internal oscillator");
  comp_resync_a: assert property ($changed(COMP_SYNC_OUT)
    |-> COMP_SYNC_OUT == $past(COMP_OUT)) else $error("resync output not comparator");
  irq_hold_a: assert property ($fell(IRQ_REQ) |-> $past(req && WB_WE_I))
    else $error("request dropped by hardware");
  wake_hold_a: assert property ($fell(WAKE_REQ) |-> $past(req && WB_WE_I))
    else $error("wake dropped by hardware");
endmodule : gated_counter_monitor

bind gated_counter gated_counter_monitor mon (.CLK(CLK), .RESETN(RESETN),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .COMP_OUT(COMP_OUT),
  .INTERNAL_OSC_NO_CLOCK_OUTPUT_PIN(INTERNAL_OSC_NO_CLOCK_OUTPUT_PIN), .IRQ_REQ(IRQ_REQ), .WAKE_REQ(WAKE_REQ),
  .LP_OSC_EN(LP_OSC_EN), .COMP_SYNC_OUT(COMP_SYNC_OUT));
`default_nettype wire

// ==== testbench/ext_source.sv ====
/*
  External count clock source.
  Assumes the caller asks for bursts; the pin rests at its idle level between them.
*/
`default_nettype none
module ext_source (
  input wire logic clk,
  input wire logic idle,
  output logic     pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic active = 1'b0;
  assign pin = active ^ idle;

  // Idle high gives fall then rise, so every pulse counts
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge clk);
      active <= 1'b1;
      repeat (4) @(posedge clk);
      active <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : burst
endmodule : ext_source
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench for the gated counter.
  Assumes the monitor is bound and ext_source plays the count clock.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RESETN, cyc, we, gate, comp, trig, sleep, internal_osc, idle;
  logic [7:0]  adr;
  logic [31:0] dat, rd;
  logic [15:0] c;
  wire logic [31:0] dout;
  wire logic ack, ext, irq, wake, lpo, csync;
  int err_total, cmp_count;

  gated_counter dut (.CLK(CLK), .RESETN(RESETN), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dout),
    .WB_ACK_O(ack), .EXT_CLK_PIN(ext), .GATE_PIN(gate), .COMP_OUT(comp),
    .SPECIAL_TRIGGER(trig), .SLEEP(sleep), .INTERNAL_OSC_NO_CLOCK_OUTPUT_PIN(internal_osc), .IRQ_REQ(irq),
    .WAKE_REQ(wake), .LP_OSC_EN(lpo), .COMP_SYNC_OUT(csync));
  ext_source src (.clk(CLK), .idle(idle), .pin(ext));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Trigger rides along with the request so both meet at the taken edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic t = 1'b0);
    @(posedge CLK);
    cyc <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d}; trig <= t;
    @(posedge CLK);
    trig <= 1'b0;
    while (ack !== 1'b1) @(posedge CLK);
    rd = dout;
    cyc <= 1'b0;
  endtask : wb

  task automatic rdc;
    wb(0, 8'h04, 0); c[7:0] = rd[7:0];
    wb(0, 8'h08, 0); c[15:8] = rd[7:0];
  endtask : rdc

  task automatic setc(input logic [15:0] v);
    wb(1, 8'h00, 0); wb(1, 8'h04, v[7:0]); wb(1, 8'h08, v[15:8]);
  endtask : setc

  task automatic t_regs;
    wb(0, 8'h00, 0); chk("control", rd, 0);
    wb(0, 8'h18, 0); chk("cmp ctrl", rd, 32'h2);
    wb(1, 8'h00, 8'hA5); wb(0, 8'h00, 0); chk("control rw", rd, 32'hA5);
    wb(1, 8'h40, 8'hFF); wb(0, 8'h40, 0); chk("unmapped", rd, 0);
    wb(1, 8'h00, 8'h08); chk("lp osc off", lpo, 0);
    internal_osc <= 1'b1; repeat (2) @(posedge CLK); chk("lp osc on", lpo, 1);
    internal_osc <= 1'b0;
  endtask : t_regs

  task automatic t_ext;
    // Gate pin held inactive, but reset selects the comparator gate, which is active: with gate enable clear it must not matter
    gate <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      setc(0);
      idle <= (i != 4);
      wb(1, 8'h00, {2'b00, i[1:0], 1'b0, i[0], 2'b11});
      src.burst(8);
      rdc(); chk("ext count", c, (i == 4) ? 7 : (8 >> i));
    end
  endtask : t_ext

  task automatic t_gate;
    // Idle high again, so every pulse falls before it rises
    idle <= 1'b1;
    for (int j = 0; j < 8; j++) begin
      // Levels set early so the resync stage settles while stopped
      gate <= j[0] ^ j[2];
      comp <= ~(j[0] ^ j[2]);
      setc(0);
      wb(1, 8'h18, {6'h0, j[2], j[1]});
      wb(1, 8'h00, {j[1], 7'h47});
      src.burst(4);
      rdc(); chk("gated count", c, (j[0] == j[1]) ? 4 : 0);
      chk("comp sync", csync, {31'h0, ~(j[0] ^ j[2])});
    end
  endtask : t_gate

  task automatic t_ovf;
    setc(16'hFFFF);
    wb(1, 8'h18, 8'h00); wb(1, 8'h10, 8'h01); wb(1, 8'h14, 8'hC0);
    wb(1, 8'h00, 8'h07);
    sleep <= 1'b1;
    src.burst(1);
    sleep <= 1'b0;
    rdc(); chk("wrap", c, 0);
    wb(0, 8'h0C, 0); chk("flag", rd, 1);
    chk("irq", irq, 1); chk("wake", wake, 1);
    wb(1, 8'h14, 8'h40); chk("irq no gie", irq, 0); chk("wake no gie", wake, 1);
    wb(1, 8'h0C, 0); chk("wake cleared", wake, 0);
    src.burst(3);
    setc(16'hFFFF);
    wb(1, 8'h00, 8'h03);
    @(posedge CLK) trig <= 1'b1;
    @(posedge CLK) trig <= 1'b0;
    rdc(); chk("trigger clear", c, 0);
    wb(0, 8'h0C, 0); chk("no flag", rd, 0);
    setc(16'h1200);
    wb(1, 8'h04, 8'h55, 1'b1); rdc(); chk("write wins", c, 16'h1255);
  endtask : t_ovf

  task automatic conclude;
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    conclude();
  end

  initial begin
    RESETN = 0; cyc = 0; we = 0; adr = 0; dat = 0; gate = 0; comp = 0;
    trig = 0; sleep = 0; internal_osc = 0; idle = 1;
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    t_regs(); t_ext(); t_gate(); t_ovf();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
